/* hw/pbc_pkg.sv */
package pbc_pkg;

  localparam int REG_W = 16;
  localparam int IDX_W = 5;

  // Register indices
  localparam logic [4:0] IDX_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] IDX_BASIC_STATUS = 5'h01;
  localparam logic [4:0] IDX_IDENTIFIER_HIGH = 5'h02;
  localparam logic [4:0] IDX_IDENTIFIER_LOW = 5'h03;
  localparam logic [4:0] IDX_NEGOTIATION_ADVERTISE = 5'h04;
  localparam logic [4:0] IDX_PARTNER_ABILITY = 5'h05;
  localparam logic [4:0] IDX_NEGOTIATION_EXPANSION = 5'h06;
  localparam logic [4:0] IDX_NEXT_PAGE_TRANSMIT = 5'h07;
  localparam logic [4:0] IDX_NEXT_PAGE_RECEIVE = 5'h08;
  localparam logic [4:0] IDX_INDIRECT_ACCESS_CONTROL = 5'h0D;
  localparam logic [4:0] IDX_INDIRECT_ADDRESS_DATA = 5'h0E;
  localparam logic [4:0] IDX_IDLE_POWER_CROSSOVER_CONFIG = 5'h10;
  localparam logic [4:0] IDX_OPERATING_CONTROL_STATUS = 5'h11;
  localparam logic [4:0] IDX_SPECIAL_SETTINGS = 5'h12;
  localparam logic [4:0] IDX_CABLE_TEST_PATTERN_DELAY = 5'h18;
  localparam logic [4:0] IDX_CABLE_TEST_CONTROL_STATUS = 5'h19;
  localparam logic [4:0] IDX_SYMBOL_ERROR_COUNT = 5'h1A;
  localparam logic [4:0] IDX_SPECIAL_INDICATIONS = 5'h1B;
  localparam logic [4:0] IDX_CABLE_LENGTH = 5'h1C;
  localparam logic [4:0] IDX_INTERRUPT_SOURCE_FLAGS = 5'h1D;
  localparam logic [4:0] IDX_INTERRUPT_MASK = 5'h1E;
  localparam logic [4:0] IDX_PHY_SPECIAL_CONTROL_STATUS = 5'h1F;

  // Map presence, one bit per index
  localparam logic [31:0] IDX_PRESENT = 32'hFF07_61FF;

  // Basic control field positions
  localparam int BC_SOFT_RESET = 15;
  localparam int BC_LOOPBACK = 14;
  localparam int BC_SPEED_100 = 13;
  localparam int BC_AUTONEG_EN = 12;
  localparam int BC_POWER_DOWN = 11;
  localparam int BC_ISOLATE = 10;
  localparam int BC_AUTONEG_RESTART = 9;
  localparam int BC_FULL_DUPLEX = 8;
  localparam int BC_COLLISION_TEST = 7;
  localparam logic [15:0] BC_WRITABLE_MASK = 16'h7D80;

  // Basic status constant abilities
  localparam logic [15:0] BASIC_STATUS_VALUE = 16'h7809;
  localparam int BS_AUTONEG_DONE = 5;
  localparam int BS_LINK_UP = 2;

  // Identifier values, arbitrary neutral codes
  localparam logic [15:0] IDENT_HIGH_RESET = 16'h1234;
  localparam logic [15:0] IDENT_LOW_RESET = 16'h5670;

  // Soft reset duration in ns and cycles at 25 MHz
  localparam int CLK_PERIOD_NS = 40;
  localparam int SOFT_RESET_NS = 400;
  localparam int SOFT_RESET_CYC = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 4;

  // Soft reset sequencer states
  typedef enum logic [1:0] {
    PBC_IDLE = 2'b00,
    PBC_RESETTING = 2'b01,
    PBC_RELEASE = 2'b10
  } pbc_state_t;

endpackage

/* hw/pbc_strap_sync.sv */
`timescale 1ns/1ns
// Two-stage synchroniser for the three strap levels
module pbc_strap_sync
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] async_in,
  output logic [2:0] sync_out
);

  logic [2:0] meta_q;
  logic [2:0] meta_d;
  logic [2:0] sync_q;
  logic [2:0] sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

/* hw/pbc_regs.sv */
`timescale 1ns/1ns
// Operation
// - Registers at indices 0-8, 13-14, 16-18 and 24-31
// - Index comes from management frame field
// - Bit 15 soft reset, self-clearing
// - Soft reset keeps register config, not straps
// - Bit 14 loopback, resets zero
// - Bit 13 speed, ignored under autoneg
// - Bit 12 autoneg enable overrides forcing
// - Bit 8 duplex, ignored under autoneg
// - Speed, duplex, autoneg defaults from straps
// - Bit 11 power down, resets zero
// - Bit 10 isolates MAC-side interface
// - Bit 9 restarts autoneg, self-clearing
// - Bit 7 collision test, resets zero
module pbc_regs
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic [2:0] MODE_STRAP,
  input wire logic MGMT_WR,
  input wire logic MGMT_RD,
  input wire logic [4:0] MGMT_INDEX,
  input wire logic [15:0] MGMT_WDATA,
  input wire logic AUTONEG_DONE_IN,
  input wire logic LINK_UP_IN,
  output logic [15:0] MGMT_RDATA,
  output logic MGMT_RVALID,
  output logic SOFT_RESET_ACTIVE,
  output logic LOOPBACK,
  output logic SPEED_100,
  output logic FULL_DUPLEX,
  output logic AUTONEG_EN,
  output logic AUTONEG_RESTART,
  output logic POWER_DOWN,
  output logic ISOLATE,
  output logic COLLISION_TEST
);

  function automatic logic idx_present(input logic [4:0] idx);
    idx_present = pbc_pkg::IDX_PRESENT[idx];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Strap capture

  logic [2:0] strap_sync;
  logic straps_taken_q;
  logic straps_taken_d;
  logic [2:0] strap_q;
  logic [2:0] strap_d;

  pbc_strap_sync u_sync
  (
    .clk(SYS_CLK),
    .rst(RESET),
    .async_in(MODE_STRAP),
    .sync_out(strap_sync)
  );

  // Straps settle through the synchroniser, then latch once; soft reset never re-takes them
  logic [1:0] settle_q;
  logic [1:0] settle_d;

  always_comb
  begin
    settle_d = settle_q;
    straps_taken_d = straps_taken_q;
    strap_d = strap_q;
    if (settle_q != 2'h3)
      settle_d = settle_q + 2'h1;
    else if (!straps_taken_q)
    begin
      straps_taken_d = 1'b1;
      strap_d = strap_sync;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      settle_q <= 2'h0;
      straps_taken_q <= 1'b0;
      strap_q <= 3'h0;
    end
    else
    begin
      settle_q <= settle_d;
      straps_taken_q <= straps_taken_d;
      strap_q <= strap_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Basic control register and soft reset sequencer

  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  pbc_pkg::pbc_state_t state_q;
  pbc_pkg::pbc_state_t state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic wr_ctrl;

  assign wr_ctrl = MGMT_WR && (MGMT_INDEX == pbc_pkg::IDX_BASIC_CONTROL);

  always_comb
  begin
    ctrl_d = ctrl_q;
    state_d = state_q;
    cnt_d = cnt_q;
    // Restart is a one-cycle request toward negotiation logic
    ctrl_d[pbc_pkg::BC_AUTONEG_RESTART] = 1'b0;
    case (state_q)
      pbc_pkg::PBC_IDLE:
      begin
        if (!straps_taken_q)
        begin
          // Straps give speed, duplex and autoneg reset defaults
          ctrl_d[pbc_pkg::BC_SPEED_100] = strap_d[0];
          ctrl_d[pbc_pkg::BC_FULL_DUPLEX] = strap_d[1];
          ctrl_d[pbc_pkg::BC_AUTONEG_EN] = strap_d[2];
        end
        else if (wr_ctrl && MGMT_WDATA[pbc_pkg::BC_SOFT_RESET])
        begin
          // Config bits untouched so the current values survive the reset
          ctrl_d[pbc_pkg::BC_SOFT_RESET] = 1'b1;
          state_d = pbc_pkg::PBC_RESETTING;
          cnt_d = 4'(pbc_pkg::SOFT_RESET_CYC - 1);
        end
        else if (wr_ctrl)
        begin
          // Reserved bits and bit 15 are masked off; bit 9 passes through as the restart request
          ctrl_d = MGMT_WDATA & pbc_pkg::BC_WRITABLE_MASK;
          ctrl_d[pbc_pkg::BC_AUTONEG_RESTART] =
            MGMT_WDATA[pbc_pkg::BC_AUTONEG_RESTART];
        end
      end
      pbc_pkg::PBC_RESETTING:
      begin
        // Writes during the reset window are ignored
        if (cnt_q == 4'h0)
          state_d = pbc_pkg::PBC_RELEASE;
        else
          cnt_d = cnt_q - 4'h1;
      end
      pbc_pkg::PBC_RELEASE:
      begin
        ctrl_d[pbc_pkg::BC_SOFT_RESET] = 1'b0;
        // Non-config bits return to their zero reset value
        ctrl_d[pbc_pkg::BC_LOOPBACK] = 1'b0;
        ctrl_d[pbc_pkg::BC_POWER_DOWN] = 1'b0;
        ctrl_d[pbc_pkg::BC_ISOLATE] = 1'b0;
        ctrl_d[pbc_pkg::BC_COLLISION_TEST] = 1'b0;
        state_d = pbc_pkg::PBC_IDLE;
      end
      default:
      begin
        state_d = pbc_pkg::PBC_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      ctrl_q <= 16'h0000;
      state_q <= pbc_pkg::PBC_IDLE;
      cnt_q <= 4'h0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Effective operating outputs

  logic speed_d;
  logic duplex_d;
  logic speed_q;
  logic duplex_q;
  logic restart_q;
  logic [6:0] mode_q;
  logic [6:0] mode_d;

  always_comb
  begin
    // Under autoneg the forced bits do not steer the line
    if (ctrl_q[pbc_pkg::BC_AUTONEG_EN])
    begin
      speed_d = speed_q;
      duplex_d = duplex_q;
    end
    else
    begin
      speed_d = ctrl_q[pbc_pkg::BC_SPEED_100];
      duplex_d = ctrl_q[pbc_pkg::BC_FULL_DUPLEX];
    end
    mode_d[0] = ctrl_q[pbc_pkg::BC_LOOPBACK];
    mode_d[1] = ctrl_q[pbc_pkg::BC_AUTONEG_EN];
    mode_d[2] = ctrl_q[pbc_pkg::BC_POWER_DOWN];
    mode_d[3] = ctrl_q[pbc_pkg::BC_ISOLATE];
    mode_d[4] = ctrl_q[pbc_pkg::BC_COLLISION_TEST];
    mode_d[5] = ctrl_q[pbc_pkg::BC_SOFT_RESET];
    mode_d[6] = ctrl_q[pbc_pkg::BC_AUTONEG_RESTART];
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      speed_q <= 1'b0;
      duplex_q <= 1'b0;
      mode_q <= 7'h00;
    end
    else
    begin
      speed_q <= speed_d;
      duplex_q <= duplex_d;
      mode_q <= mode_d;
    end
  end

  assign restart_q = mode_q[6];
  assign SPEED_100 = speed_q;
  assign FULL_DUPLEX = duplex_q;
  assign LOOPBACK = mode_q[0];
  assign AUTONEG_EN = mode_q[1];
  assign POWER_DOWN = mode_q[2];
  assign ISOLATE = mode_q[3];
  assign COLLISION_TEST = mode_q[4];
  assign SOFT_RESET_ACTIVE = mode_q[5];
  assign AUTONEG_RESTART = restart_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [15:0] ident_high_q;
  logic [15:0] ident_high_d;
  logic [15:0] ident_low_q;
  logic [15:0] ident_low_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [1:0] status_sync_meta_q;
  logic [1:0] status_sync_q;

  always_comb
  begin
    ident_high_d = ident_high_q;
    ident_low_d = ident_low_q;
    if (MGMT_WR && (MGMT_INDEX == pbc_pkg::IDX_IDENTIFIER_HIGH))
      ident_high_d = MGMT_WDATA;
    if (MGMT_WR && (MGMT_INDEX == pbc_pkg::IDX_IDENTIFIER_LOW))
      ident_low_d = MGMT_WDATA;
    rvalid_d = MGMT_RD;
    rdata_d = 16'h0000;
    if (MGMT_RD && idx_present(MGMT_INDEX))
    begin
      case (MGMT_INDEX)
        pbc_pkg::IDX_BASIC_CONTROL:
          rdata_d = ctrl_q;
        pbc_pkg::IDX_BASIC_STATUS:
        begin
          rdata_d = pbc_pkg::BASIC_STATUS_VALUE;
          rdata_d[pbc_pkg::BS_AUTONEG_DONE] = status_sync_q[0];
          rdata_d[pbc_pkg::BS_LINK_UP] = status_sync_q[1];
        end
        pbc_pkg::IDX_IDENTIFIER_HIGH:
          rdata_d = ident_high_q;
        pbc_pkg::IDX_IDENTIFIER_LOW:
          rdata_d = ident_low_q;
        // Other mapped registers belong to blocks outside this bank
        default:
          rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      ident_high_q <= pbc_pkg::IDENT_HIGH_RESET;
      ident_low_q <= pbc_pkg::IDENT_LOW_RESET;
      rdata_q <= 16'h0000;
      rvalid_q <= 1'b0;
      status_sync_meta_q <= 2'h0;
      status_sync_q <= 2'h0;
    end
    else
    begin
      ident_high_q <= ident_high_d;
      ident_low_q <= ident_low_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      status_sync_meta_q <= {LINK_UP_IN, AUTONEG_DONE_IN};
      status_sync_q <= status_sync_meta_q;
    end
  end

  assign MGMT_RDATA = rdata_q;
  assign MGMT_RVALID = rvalid_q;

endmodule

/* testbench/pbc_props.sv */
`timescale 1ns/1ns
module pbc_props
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic MGMT_WR,
  input wire logic MGMT_RD,
  input wire logic [4:0] MGMT_INDEX,
  input wire logic [15:0] MGMT_WDATA,
  input wire logic [15:0] MGMT_RDATA,
  input wire logic MGMT_RVALID,
  input wire logic SOFT_RESET_ACTIVE,
  input wire logic LOOPBACK,
  input wire logic SPEED_100,
  input wire logic FULL_DUPLEX,
  input wire logic AUTONEG_EN,
  input wire logic AUTONEG_RESTART,
  input wire logic POWER_DOWN,
  input wire logic ISOLATE,
  input wire logic COLLISION_TEST
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);
  ////////////////////////////////////////////////////////////////////////////////
  // A write right behind a soft reset request is refused before the pin rises
  sequence s_ctl_wr;
    MGMT_WR && MGMT_INDEX == pbc_pkg::IDX_BASIC_CONTROL && !SOFT_RESET_ACTIVE &&
      !($past(MGMT_WR) && $past(MGMT_WDATA[15]) &&
      $past(MGMT_INDEX) == pbc_pkg::IDX_BASIC_CONTROL);
  endsequence
  sequence s_plain_wr;
    s_ctl_wr ##0 !MGMT_WDATA[15];
  endsequence
  // A write lands in the register, then one more stage to the pin
  property p_follow(b, o);
    s_plain_wr |-> ##2 o == $past(MGMT_WDATA[b], 2);
  endproperty
  property p_forced(b, o);
    s_plain_wr ##0 !MGMT_WDATA[12] |-> ##2 o == $past(MGMT_WDATA[b], 2);
  endproperty
  ////////////////////////////////////////////////////////////////////////////////
  AST_LOOPBACK: assert property (p_follow(14, LOOPBACK))
    else $error("loopback pin wrong after write");
  AST_POWER_DOWN: assert property (p_follow(11, POWER_DOWN))
    else $error("power down pin wrong after write");
  AST_ISOLATE: assert property (p_follow(10, ISOLATE))
    else $error("isolate pin wrong after write");
  AST_COL_TEST: assert property (p_follow(7, COLLISION_TEST))
    else $error("collision test pin wrong after write");
  AST_SPEED: assert property (p_forced(13, SPEED_100))
    else $error("forced speed not applied");
  AST_DUPLEX: assert property (p_forced(8, FULL_DUPLEX))
    else $error("forced duplex not applied");
  AST_AN_HOLD: assert property (AUTONEG_EN && $past(AUTONEG_EN) |->
    $stable(SPEED_100) && $stable(FULL_DUPLEX)) else $error("forcing moved under autoneg");
  AST_RESTART: assert property (s_plain_wr ##0 MGMT_WDATA[9] |->
    ##2 AUTONEG_RESTART ##1 !AUTONEG_RESTART) else $error("restart pulse wrong");
  AST_SRST: assert property (s_ctl_wr ##0 MGMT_WDATA[15] |->
    ##2 SOFT_RESET_ACTIVE [*8] ##[1:6] !SOFT_RESET_ACTIVE) else $error("soft reset length");
  AST_SRST_END: assert property ($fell(SOFT_RESET_ACTIVE) |-> !LOOPBACK &&
    !POWER_DOWN && !ISOLATE && !COLLISION_TEST && $stable(SPEED_100))
    else $error("soft reset end state wrong");
  AST_RVALID: assert property (MGMT_RD |=> MGMT_RVALID)
    else $error("read not answered");
  AST_HOLE: assert property (MGMT_RD && !pbc_pkg::IDX_PRESENT[MGMT_INDEX] |=>
    MGMT_RDATA == 16'h0000) else $error("unmapped read not zero");
endmodule

bind pbc_regs pbc_props u_props (.SYS_CLK(SYS_CLK), .RESET(RESET), .MGMT_WR(MGMT_WR),
  .MGMT_RD(MGMT_RD), .MGMT_INDEX(MGMT_INDEX), .MGMT_WDATA(MGMT_WDATA),
  .MGMT_RDATA(MGMT_RDATA), .MGMT_RVALID(MGMT_RVALID), .SOFT_RESET_ACTIVE(SOFT_RESET_ACTIVE),
  .LOOPBACK(LOOPBACK), .SPEED_100(SPEED_100), .FULL_DUPLEX(FULL_DUPLEX),
  .AUTONEG_EN(AUTONEG_EN), .AUTONEG_RESTART(AUTONEG_RESTART), .POWER_DOWN(POWER_DOWN),
  .ISOLATE(ISOLATE), .COLLISION_TEST(COLLISION_TEST));

/* testbench/pbc_mgmt_model.sv */
`timescale 1ns/1ns
module pbc_mgmt_model
(
  input wire logic SYS_CLK,
  input wire logic [15:0] MGMT_RDATA,
  input wire logic MGMT_RVALID,
  output logic MGMT_WR,
  output logic MGMT_RD,
  output logic [4:0] MGMT_INDEX,
  output logic [15:0] MGMT_WDATA
);
  initial
  begin
    MGMT_WR = 1'b0;
    MGMT_RD = 1'b0;
    MGMT_INDEX = 5'h1F;
    MGMT_WDATA = 16'h0000;
  end
  // Idle lines show the inverse so stale values never look valid
  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    logic [15:0] v;
    v = (idx != 5'h00) ? d : (d[15] ? 16'h8000 : (d & 16'hFF80));
    @(negedge SYS_CLK);
    MGMT_WR = 1'b1;
    MGMT_INDEX = idx;
    MGMT_WDATA = v;
    @(negedge SYS_CLK);
    MGMT_WR = 1'b0;
    MGMT_INDEX = ~idx;
    MGMT_WDATA = ~v;
  endtask
  task automatic rd(input logic [4:0] idx, output logic [15:0] d);
    @(negedge SYS_CLK);
    MGMT_RD = 1'b1;
    MGMT_INDEX = idx;
    @(negedge SYS_CLK);
    MGMT_RD = 1'b0;
    MGMT_INDEX = ~idx;
    d = MGMT_RVALID ? MGMT_RDATA : 16'hXXXX;
  endtask
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ns
module tb;
  logic SYS_CLK, RESET, AUTONEG_DONE_IN, LINK_UP_IN;
  logic [2:0] MODE_STRAP;
  logic MGMT_WR, MGMT_RD, MGMT_RVALID, SOFT_RESET_ACTIVE, LOOPBACK, SPEED_100, FULL_DUPLEX;
  logic AUTONEG_EN, AUTONEG_RESTART, POWER_DOWN, ISOLATE, COLLISION_TEST;
  logic [4:0] MGMT_INDEX;
  logic [15:0] MGMT_WDATA, MGMT_RDATA, rv;
  int n_fail, tests_run, cycles;
  pbc_mgmt_model u_mgr (.SYS_CLK(SYS_CLK), .MGMT_RDATA(MGMT_RDATA), .MGMT_RVALID(MGMT_RVALID),
    .MGMT_WR(MGMT_WR), .MGMT_RD(MGMT_RD), .MGMT_INDEX(MGMT_INDEX), .MGMT_WDATA(MGMT_WDATA));
  pbc_regs DUT (.SYS_CLK(SYS_CLK), .RESET(RESET), .MODE_STRAP(MODE_STRAP), .MGMT_WR(MGMT_WR),
    .MGMT_RD(MGMT_RD), .MGMT_INDEX(MGMT_INDEX), .MGMT_WDATA(MGMT_WDATA),
    .AUTONEG_DONE_IN(AUTONEG_DONE_IN), .LINK_UP_IN(LINK_UP_IN), .MGMT_RDATA(MGMT_RDATA),
    .MGMT_RVALID(MGMT_RVALID), .SOFT_RESET_ACTIVE(SOFT_RESET_ACTIVE), .LOOPBACK(LOOPBACK),
    .SPEED_100(SPEED_100), .FULL_DUPLEX(FULL_DUPLEX), .AUTONEG_EN(AUTONEG_EN),
    .AUTONEG_RESTART(AUTONEG_RESTART), .POWER_DOWN(POWER_DOWN), .ISOLATE(ISOLATE),
    .COLLISION_TEST(COLLISION_TEST));
  ////////////////////////////////////////////////////////////////////////////////
  initial SYS_CLK = 1'b0;
  always #20 SYS_CLK = ~SYS_CLK;
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk16(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic rdchk(input logic [4:0] idx, input logic [15:0] e, input string nm);
    u_mgr.rd(idx, rv);
    chk16(nm, e, rv);
  endtask
  // Pins trail a write by two edges
  task automatic settle;
    repeat (3) @(negedge SYS_CLK);
  endtask
  task automatic give_verdict;
    $display("tests_run %0d n_fail %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge SYS_CLK)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_map;
    rdchk(5'h00, 16'h3000, "ctrl default");
    chk1("autoneg pin", 1'b1, AUTONEG_EN);
    chk1("loopback pin", 1'b0, LOOPBACK);
    chk1("power pin", 1'b0, POWER_DOWN);
    chk1("col pin", 1'b0, COLLISION_TEST);
    rdchk(5'h01, pbc_pkg::BASIC_STATUS_VALUE | 16'h0020, "status");
    rdchk(5'h02, pbc_pkg::IDENT_HIGH_RESET, "ident high");
    rdchk(5'h03, pbc_pkg::IDENT_LOW_RESET, "ident low");
    rdchk(5'h0F, 16'h0000, "hole 15");
    $display("t_reset_map done");
  endtask
  task automatic t_forcing;
    u_mgr.wr(5'h00, 16'h2100);
    settle();
    chk1("speed", 1'b1, SPEED_100);
    chk1("duplex", 1'b1, FULL_DUPLEX);
    u_mgr.wr(5'h00, 16'h1000);
    settle();
    chk1("speed held", 1'b1, SPEED_100);
    chk1("duplex held", 1'b1, FULL_DUPLEX);
    rdchk(5'h00, 16'h1000, "ctrl autoneg");
    $display("t_forcing done");
  endtask
  task automatic t_fields;
    int b[4] = '{14, 11, 10, 7};
    for (int i = 0; i < 4; i++)
    begin
      u_mgr.wr(5'h00, 16'h0001 << b[i]);
      settle();
      chk16("ctrl pins", 16'h0008 >> i,
        {12'h000, LOOPBACK, POWER_DOWN, ISOLATE, COLLISION_TEST});
    end
    $display("t_fields done");
  endtask
  task automatic t_restart;
    u_mgr.wr(5'h00, 16'h1200);
    // Pulse stands for one cycle only, two edges behind the write
    @(negedge SYS_CLK);
    chk1("restart pulse", 1'b1, AUTONEG_RESTART);
    @(negedge SYS_CLK);
    chk1("restart end", 1'b0, AUTONEG_RESTART);
    settle();
    rdchk(5'h00, 16'h1000, "restart cleared");
    $display("t_restart done");
  endtask
  task automatic t_soft_reset;
    u_mgr.wr(5'h00, 16'h6D80);
    settle();
    // Straps moved so a resample would show
    MODE_STRAP = 3'b110;
    u_mgr.wr(5'h00, 16'h8000);
    settle();
    chk1("srst active", 1'b1, SOFT_RESET_ACTIVE);
    for (int k = 0; k < 40 && SOFT_RESET_ACTIVE; k++)
      @(negedge SYS_CLK);
    rdchk(5'h00, 16'h2100, "after srst");
    u_mgr.wr(5'h0F, 16'hFFFF);
    rdchk(5'h0F, 16'h0000, "hole write");
    rdchk(5'h00, 16'h2100, "ctrl kept");
    $display("t_soft_reset done");
  endtask
  initial
  begin
    RESET = 1'b1;
    MODE_STRAP = 3'b101;
    AUTONEG_DONE_IN = 1'b1;
    LINK_UP_IN = 1'b0;
    n_fail = 0;
    tests_run = 0;
    cycles = 0;
    repeat (16) @(negedge SYS_CLK);
    RESET = 1'b0;
    repeat (10) @(negedge SYS_CLK);
    t_reset_map();
    t_forcing();
    t_fields();
    t_restart();
    t_soft_reset();
    give_verdict();
  end
endmodule
